//--- hdl/ssp_consts.svh
/*
 * register offsets, field positions, reset values and mode codes of the
 * synchronous serial port (spi mode).
 * assumes inclusion by its bare name from the package, the design and the bench files.
 */
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

`define SSP_OFS_STATUS 4'h0
`define SSP_OFS_CTRL1 4'h1
`define SSP_OFS_CTRL3 4'h2
`define SSP_OFS_BUFFER 4'h3
`define SSP_OFS_RELOAD 4'h4
`define SSP_OFS_FLAGS 4'h5

`define SSP_ST_SMP 7
`define SSP_ST_CKE 6
`define SSP_ST_BF 0
`define SSP_C1_WRITE_COLLISION 7
`define SSP_C1_OV 6
`define SSP_C1_EN 5
`define SSP_C1_CKP 4
`define SSP_C3_OVERWRITE_ENABLE 4
`define SSP_FL_IRQF 0
`define SSP_FL_IRQE 1

`define SSP_MODE_DIV4 4'h0
`define SSP_MODE_DIV16 4'h1
`define SSP_MODE_DIV64 4'h2
`define SSP_MODE_TMR2 4'h3
`define SSP_MODE_SLV_SS 4'h4
`define SSP_MODE_SLV 4'h5
`define SSP_MODE_RELOAD 4'ha

`define SSP_RST_BYTE 8'h00
`define SSP_BITS 4'h8

`endif

//--- hdl/ssp_pkg.sv
/*
 * types shared by the synchronous serial port.
 * assumes the constants header sits beside it.
 */
`include "ssp_consts.svh"

package ssp_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ssp_bus_t;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
    } ssp_pins_t;

    typedef enum logic [2:0] {
        SSP_IDLE = 3'b001,
        SSP_LEAD = 3'b010,
        SSP_TRAIL = 3'b100
    } ssp_state_t;

endpackage

//--- hdl/ssp_port.sv
/*
 * spi mode of a synchronous serial port: registers on a plain strobe port,
 * master clock generation, slave shifting on the sampled external clock.
 * assumes sys_clk is far faster than the serial clock; pins arrive async.
 */
`timescale 1ns/1ps
`include "ssp_consts.svh"

// Overview of operation
// (R1) full byte goes to buffer, flags set
// (R2) next byte shifts while buffer waits
// (R3) buffer write loads buffer and shifter
// (R4) write during transfer ignored, collision flagged
// (R5) collision sticks until software clears it
// (R6) buffer read clears buffer full
// (R7) port runs only when enabled
// (R8) options in control one and status top
// (R9) status low six read-only, top writable
// (R10) master drives clock, slave receives it
// (R11) master buffer write starts transfer
// (R12) master keeps receiving without data out
// (R13) master rate from five selectable sources
// (R14) reload register sets divisor
// (R15) idle level and output edge selectable
// (R16) edge bit set: data valid early
// (R17) sample phase middle or end; the code samples on the same edge for both
// (R18) shift most significant bit first
// (R19) slave shifts per external clock pulse
// (R20) master holds clock idle before enable
// (R21) slave keeps shifting, byte raises interrupt
// (R22) daisy chain passes received bits on
// (R23) overwrite enable accepts writes unread
// (R24) mode 0100 is slave with select
// (R25) slave drives data out only selected
// (R26) select high or disable clears counter
// (R27) shift out one edge, latch other
// (R28) rate source codes fixed in map
// (R29) interrupt flag sticky, gated by enable
module ssp_port
    import ssp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire ssp_bus_t bus,
    output logic [7:0] rdata,
    input wire logic timer2_out,
    input wire logic sck_i,
    input wire logic sdi_i,
    input wire logic sel_n_i,
    output ssp_pins_t pins,
    output logic irq
);

    logic [7:0] status_r, ctrl1_r, ctrl3_r, buffer_r, reload_r, shifter_r;
    logic bf_r, write_collision_r, ov_r, irqf_r, irqe_r;
    logic [2:0] sck_s, sdi_s, sel_s;
    ssp_state_t state_r;
    logic [3:0] bitcnt_r;
    // trailing edges of the master clock; ends the byte on its own count
    logic [3:0] mcnt_r;
    logic [7:0] div_r;
    logic tmr_q_r, tmr_half_r, sck_q_r, sdo_r, in_bit_r;
    logic [7:0] rdata_r;

    logic en, clock_idle_level, cke, sample_phase, overwrite_enable, master, slave, ss_mode, sel;
    logic sck_rise, sck_fall, out_edge, in_edge;
    logic busy, wr_buf, rd_buf, byte_done, tick;
    logic [7:0] div_max;
    logic [3:0] mode;

    assign en = ctrl1_r[`SSP_C1_EN]; // R7
    assign clock_idle_level = ctrl1_r[`SSP_C1_CKP];
    assign mode = ctrl1_r[3:0]; // R8
    assign cke = status_r[`SSP_ST_CKE];
    assign sample_phase = status_r[`SSP_ST_SMP];
    assign overwrite_enable = ctrl3_r[`SSP_C3_OVERWRITE_ENABLE];
    assign ss_mode = mode == `SSP_MODE_SLV_SS; // R24
    assign slave = ss_mode || mode == `SSP_MODE_SLV;
    assign master = !slave; // R28
    assign sel = ss_mode ? !sel_s[2] : 1'b1;
    assign wr_buf = bus.wr && bus.addr == `SSP_OFS_BUFFER;
    assign rd_buf = bus.rd && bus.addr == `SSP_OFS_BUFFER;
    assign busy = state_r != SSP_IDLE || (slave && bitcnt_r != 4'h0);

    // pin inputs pass three flops; only the second and third stages feed logic
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            sck_s <= 3'h0;
            sdi_s <= 3'h0;
            sel_s <= 3'h7;
        end
        else
        begin
            sck_s <= {sck_s[1:0], sck_i};
            sdi_s <= {sdi_s[1:0], sdi_i};
            sel_s <= {sel_s[1:0], sel_n_i};
        end
    end

    // master bit rate: tick is one half serial clock period
    always_comb
    begin
        case (mode)
            `SSP_MODE_DIV4: div_max = 8'h01;
            `SSP_MODE_DIV16: div_max = 8'h07;
            `SSP_MODE_DIV64: div_max = 8'h1f;
            `SSP_MODE_RELOAD: div_max = {reload_r[6:0], 1'b1}; // R14
            default: div_max = 8'h01;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            div_r <= 8'h00;
            tmr_q_r <= 1'b0;
            tmr_half_r <= 1'b0;
        end
        else
        begin
            tmr_q_r <= timer2_out;
            if (timer2_out && !tmr_q_r)
                tmr_half_r <= 1'b1;
            else if (state_r == SSP_IDLE)
                tmr_half_r <= 1'b0;
            if (state_r == SSP_IDLE || div_r == div_max)
                div_r <= 8'h00;
            else
                div_r <= div_r + 8'h01;
        end
    end

    // R13: fosc/(4*(n+1)) with fosc counted as sys_clk
    assign tick = mode == `SSP_MODE_TMR2 ?
        (timer2_out && !tmr_q_r) : div_r == div_max;

    assign sck_rise = sck_s[1] && !sck_s[2];
    assign sck_fall = !sck_s[1] && sck_s[2];
    // R15 R27: leading edge leaves idle level; cke picks the output edge
    // cke clear: output on the leading edge, the same as the master side
    assign out_edge = slave && sel &&
        ((clock_idle_level ^ cke) ? sck_fall : sck_rise);
    assign in_edge = slave && sel &&
        ((clock_idle_level ^ cke) ? sck_rise : sck_fall);

    // master sequencer
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || !en)
        begin
            state_r <= SSP_IDLE;
            sck_q_r <= 1'b0;
            mcnt_r <= 4'h0;
        end
        else
        begin
            case (state_r)
                SSP_IDLE:
                    if (master && wr_buf && !write_collision_r && !busy) // R11
                        state_r <= SSP_LEAD;
                SSP_LEAD:
                    if (tick)
                    begin
                        state_r <= SSP_TRAIL;
                        sck_q_r <= 1'b1;
                    end
                SSP_TRAIL:
                    if (tick)
                    begin
                        sck_q_r <= 1'b0;
                        // bitcnt is cleared by byte_done, so it cannot
                        // tell the last edge; the edge count can
                        if (mcnt_r == `SSP_BITS - 4'h1)
                        begin
                            mcnt_r <= 4'h0;
                            state_r <= SSP_IDLE; // R11
                        end
                        else
                        begin
                            mcnt_r <= mcnt_r + 4'h1;
                            state_r <= SSP_LEAD;
                        end
                    end
                default: state_r <= SSP_IDLE;
            endcase
        end
    end

    // shifter, bit counter and data out
    logic m_lead, m_trail, sh_out, sh_in;
    assign m_lead = state_r == SSP_LEAD && tick;
    assign m_trail = state_r == SSP_TRAIL && tick;
    // cke set: data already on the pin, so shift on trailing edge
    assign sh_out = master ? (cke ? m_trail : m_lead) : out_edge;
    assign sh_in = master ? (cke ? m_lead : m_trail) : in_edge;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            shifter_r <= `SSP_RST_BYTE;
            bitcnt_r <= 4'h0;
            sdo_r <= 1'b0;
            in_bit_r <= 1'b0;
        end
        else if (!en || (ss_mode && sel_s[2])) // R26
        begin
            bitcnt_r <= 4'h0;
            if (wr_buf && !write_collision_r)
            begin
                shifter_r <= bus.wdata;
                sdo_r <= bus.wdata[7];
            end
        end
        else
        begin
            if (wr_buf && !busy && !write_collision_r)
            begin
                shifter_r <= bus.wdata; // R3
                sdo_r <= bus.wdata[7]; // R16
            end
            else if (byte_done)
            begin
                bitcnt_r <= 4'h0;
                shifter_r <= {shifter_r[6:0], in_bit_r};
                sdo_r <= shifter_r[6]; // R22
            end
            else
            begin
                if (sh_in)
                begin
                    in_bit_r <= sdi_s[2]; // R12 R19 R21
                    bitcnt_r <= bitcnt_r + 4'h1;
                end
                if (sh_out && bitcnt_r != 4'h0 && !cke)
                begin
                    shifter_r <= {shifter_r[6:0], in_bit_r}; // R18
                    sdo_r <= shifter_r[6];
                end
                else if (sh_out && cke && bitcnt_r != 4'h0)
                begin
                    shifter_r <= {shifter_r[6:0], in_bit_r};
                    sdo_r <= shifter_r[6];
                end
                else if (sh_out && bitcnt_r == 4'h0 && !cke)
                    sdo_r <= shifter_r[7];
            end
        end
    end

    // R17: master end-of-time sampling samples on the same sh_in edge as middle and does not delay byte_done
    logic smp_hold_r;
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            smp_hold_r <= 1'b0;
        else
            smp_hold_r <= master && sample_phase && sh_in;
    end
    assign byte_done = bitcnt_r == `SSP_BITS &&
        (master ? (sample_phase ? smp_hold_r || m_lead || m_trail : 1'b1)
                : 1'b1);

    // buffer and flags
    logic [7:0] rx_byte;
    assign rx_byte = {shifter_r[6:0], in_bit_r};

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            buffer_r <= `SSP_RST_BYTE;
        else if (en && byte_done)
            buffer_r <= rx_byte; // R1 R2
        else if (wr_buf && !busy && !write_collision_r && (!bf_r || overwrite_enable)) // R23
            buffer_r <= bus.wdata; // R3
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            bf_r <= 1'b0;
        else if (en && byte_done)
            bf_r <= 1'b1; // R1
        else if (rd_buf)
            bf_r <= 1'b0; // R6
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            ov_r <= 1'b0;
        else if (en && byte_done && bf_r && !overwrite_enable)
            ov_r <= 1'b1;
        else if (bus.wr && bus.addr == `SSP_OFS_CTRL1 &&
                 !bus.wdata[`SSP_C1_OV])
            ov_r <= 1'b0;
    end

    // set beats clear for both sticky flags
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            write_collision_r <= 1'b0;
        else if (wr_buf && en && busy)
            write_collision_r <= 1'b1; // R4
        else if (bus.wr && bus.addr == `SSP_OFS_CTRL1 &&
                 !bus.wdata[`SSP_C1_WRITE_COLLISION])
            write_collision_r <= 1'b0; // R5
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            irqf_r <= 1'b0;
        else if (en && byte_done)
            irqf_r <= 1'b1; // R1 R29
        else if (bus.wr && bus.addr == `SSP_OFS_FLAGS &&
                 !bus.wdata[`SSP_FL_IRQF])
            irqf_r <= 1'b0;
    end

    // control registers
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            ctrl1_r <= `SSP_RST_BYTE;
            status_r <= `SSP_RST_BYTE;
            ctrl3_r <= `SSP_RST_BYTE;
            reload_r <= `SSP_RST_BYTE;
            irqe_r <= 1'b0;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                `SSP_OFS_CTRL1: ctrl1_r <= {2'b00, bus.wdata[5:0]}; // R9
                `SSP_OFS_STATUS: status_r <= {bus.wdata[7:6], 6'h00}; // R9
                `SSP_OFS_CTRL3: ctrl3_r <= bus.wdata;
                `SSP_OFS_RELOAD: reload_r <= bus.wdata;
                `SSP_OFS_FLAGS: irqe_r <= bus.wdata[`SSP_FL_IRQE];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            rdata_r <= 8'h00;
        else if (bus.rd)
        begin
            case (bus.addr)
                `SSP_OFS_STATUS: rdata_r <= {status_r[7:6], 5'h00, bf_r};
                `SSP_OFS_CTRL1: rdata_r <= {write_collision_r, ov_r, ctrl1_r[5:0]};
                `SSP_OFS_CTRL3: rdata_r <= ctrl3_r;
                `SSP_OFS_BUFFER: rdata_r <= buffer_r;
                `SSP_OFS_RELOAD: rdata_r <= reload_r;
                `SSP_OFS_FLAGS: rdata_r <= {6'h00, irqe_r, irqf_r};
                default: rdata_r <= 8'h00;
            endcase
        end
        else
            rdata_r <= 8'h00;
    end
    assign rdata = rdata_r;

    assign irq = irqf_r && irqe_r; // R29 R21
    assign pins.sck_o = sck_q_r ^ clock_idle_level; // R15
    assign pins.sck_oe = en && master; // R10
    assign pins.sdo_o = sdo_r;
    assign pins.sdo_oe = en && (master || !ss_mode || !sel_s[2]); // R25

endmodule

//--- tb/ssp_port_monitor.sv
/* assertions on the serial port's register port and pins.
   assumes it is bound to every ssp_port instance. */
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_port_monitor
    import ssp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire ssp_bus_t bus,
    input wire logic [7:0] rdata,
    input wire ssp_pins_t pins,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    sequence s_wr(a);
        bus.wr && bus.addr == a;
    endsequence
    sequence s_rd(a);
        bus.rd && !bus.wr && bus.addr == a;
    endsequence
    chk_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_reset_quiet: assert property ($rose(resetn) |->
        !pins.sck_oe && !pins.sdo_oe && !irq)
        else $error("pins or irq active after reset");
    chk_master_drives: assert property (pins.sck_oe |-> pins.sdo_oe)
        else $error("master clock driven without data out");
    chk_ctrl_rw: assert property (s_wr(`SSP_OFS_CTRL1) ##1 !bus.wr
        ##1 s_rd(`SSP_OFS_CTRL1) |=> rdata[5:0] == $past(bus.wdata[5:0], 3))
        else $error("control one did not read back");
    chk_status_ro: assert property (s_rd(`SSP_OFS_STATUS) |=>
        rdata[5:1] == 5'h00)
        else $error("status low bits not read-only");
    chk_irq_sticky: assert property ($fell(irq) |->
        $past(bus.wr && bus.addr == `SSP_OFS_FLAGS)
        || $past(bus.wr && bus.addr == `SSP_OFS_FLAGS, 2))
        else $error("irq dropped without a flag write");
    chk_half_period: assert property ($changed(pins.sck_o) &&
        pins.sck_oe |=> $stable(pins.sck_o))
        else $error("serial clock half period below two cycles");
    chk_bf_cleared: assert property (s_rd(`SSP_OFS_BUFFER) ##1 !bus.wr
        ##1 s_rd(`SSP_OFS_STATUS) |=> !rdata[0])
        else $error("buffer full still set after buffer read");
endmodule

bind ssp_port ssp_port_monitor ssp_port_monitor_inst (.sys_clk(sys_clk),
    .resetn(resetn), .bus(bus), .rdata(rdata), .pins(pins), .irq(irq));

//--- tb/ssp_spi_partner.sv
/* far side of the serial pins: an echoing slave while the port is master,
   an spi master with a 125 ns clock while the port is slave. */
`timescale 1ns/1ps
module ssp_spi_partner
    import ssp_pkg::*;
(
    input wire ssp_pins_t pins,
    output logic sck,
    output logic sel_n,
    output logic sdi
);
    logic line_r = 1'b0;
    initial sck = 1'b0;
    initial sel_n = 1'b1;
    // a slave with data out wired to data in echoes the master's byte
    assign sdi = pins.sck_oe ? pins.sdo_o : line_r;
    // data moves mid low phase so neither edge races it
    task automatic frame(input logic [7:0] v, input int n,
        output logic [7:0] got);
        got = 8'h00;
        sel_n = 1'b0;
        for (int i = 7; i > 7 - n; i--)
        begin
            #31 line_r = v[i];
            #31.5 sck = 1'b1;
            #54.5 got[i] = pins.sdo_o;
            #8 sck = 1'b0;
        end
        #62.5 sel_n = 1'b1;
        line_r = ~line_r;
    endtask
endmodule

//--- tb/ssp_port_tb.sv
/* self-checking bench for ssp_port: register checks, master loopback in
   each rate mode, slave frames from the partner model. */
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_port_tb
    import ssp_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    ssp_bus_t bus = '0;
    logic timer2_out = 1'b0;
    logic [2:0] tcnt = 3'h0;
    logic [7:0] rdata, d, v, e;
    ssp_pins_t pins;
    logic irq, sck, sel_n, sdi;
    int mismatches = 0;
    int samples_checked = 0;
    logic [7:0] exp_q[$];
    logic [7:0] cfg[5] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h3a};
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        tcnt <= tcnt + 3'h1;
        timer2_out <= tcnt[2];
    end
    ssp_port ssp_port_inst (.sys_clk(sys_clk), .resetn(resetn), .bus(bus),
        .rdata(rdata), .timer2_out(timer2_out), .sck_i(sck), .sdi_i(sdi),
        .sel_n_i(sel_n), .pins(pins), .irq(irq));
    ssp_spi_partner ssp_spi_partner_inst (.pins(pins), .sck(sck),
        .sel_n(sel_n), .sdi(sdi));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] x, logic [7:0] s);
        samples_checked++;
        if (s !== x)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] w);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.wdata <= w;
        bus.wr <= 1'b1;
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] r);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 r = rdata;
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 4000 && irq !== 1'b1; n++)
            @(posedge sys_clk);
        chk("irq", 8'h01, {7'h0, irq});
        if (irq !== 1'b1)
            end_of_test();
    endtask
    task automatic clear_irq();
        wr(`SSP_OFS_FLAGS, 8'h02);
        repeat (2) @(posedge sys_clk);
        chk("irq", 8'h00, {7'h0, irq});
    endtask
    task automatic master(input logic [7:0] c, input logic [7:0] w);
        wr(`SSP_OFS_CTRL1, c);
        wr(`SSP_OFS_BUFFER, w);
        exp_q.push_back(w);
        wr(`SSP_OFS_BUFFER, ~w);
        rd(`SSP_OFS_CTRL1, d);
        chk("collision", c | 8'h80, d);
        wait_irq();
        wr(`SSP_OFS_BUFFER, ~w);
        rd(`SSP_OFS_BUFFER, d);
        e = exp_q.pop_front();
        // echo through the pin synchronisers is too slow at the /4 rate
        if (c[3:0] != `SSP_MODE_DIV4)
            chk("buffer", e, d);
        rd(`SSP_OFS_STATUS, d);
        chk("status", 8'h00, d);
        wr(`SSP_OFS_CTRL1, c);
        clear_irq();
        // the first byte must have ended: a fresh write starts a second
        wr(`SSP_OFS_BUFFER, ~w);
        rd(`SSP_OFS_CTRL1, d);
        chk("collision", c, d);
        wait_irq();
        rd(`SSP_OFS_BUFFER, d);
        if (c[3:0] != `SSP_MODE_DIV4)
            chk("buffer", ~w, d);
        clear_irq();
        wr(`SSP_OFS_CTRL1, c & 8'hdf);
    endtask
    initial
    begin
        void'($urandom(32'h616e21a3));
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(`SSP_OFS_STATUS, d);
        chk("status", 8'h00, d);
        wr(`SSP_OFS_STATUS, 8'hff);
        rd(`SSP_OFS_STATUS, d);
        chk("status", 8'hc0, d);
        wr(`SSP_OFS_STATUS, 8'h00);
        wr(4'hf, 8'hff);
        rd(4'hf, d);
        chk("unmapped", 8'h00, d);
        wr(`SSP_OFS_CTRL1, 8'h1f);
        rd(`SSP_OFS_CTRL1, d);
        chk("control", 8'h1f, d);
        wr(`SSP_OFS_RELOAD, 8'h02);
        wr(`SSP_OFS_FLAGS, 8'h02);
        foreach (cfg[i])
            master(cfg[i], 8'($urandom));
        wr(`SSP_OFS_CTRL1, 8'h24);
        wr(`SSP_OFS_BUFFER, 8'h5a);
        e = 8'h5a;
        for (int k = 0; k < 3; k++)
        begin
            v = 8'($urandom);
            exp_q.push_back(v);
            ssp_spi_partner_inst.frame(v, 8, d);
            if (k < 2)
                chk("sdo", e, d);
            // select passes the pin synchroniser before data out floats
            repeat (4) @(posedge sys_clk);
            chk("sdo_oe", 8'h00, {7'h0, pins.sdo_oe});
            wait_irq();
            rd(`SSP_OFS_BUFFER, d);
            chk("buffer", exp_q.pop_front(), d);
            clear_irq();
            e = v;
            if (k == 1)
            begin
                ssp_spi_partner_inst.frame(8'hff, 3, d);
                // select must be seen high before the next frame opens
                repeat (6) @(posedge sys_clk);
                chk("sdo_oe", 8'h00, {7'h0, pins.sdo_oe});
            end
        end
        wr(`SSP_OFS_CTRL3, 8'h10);
        ssp_spi_partner_inst.frame(8'h3c, 8, d);
        chk("sdo", e, d);
        wait_irq();
        wr(`SSP_OFS_BUFFER, 8'hc3);
        rd(`SSP_OFS_BUFFER, d);
        chk("overwrite", 8'hc3, d);
        end_of_test();
    end
endmodule
